//--- hw/key_detect_regs.sv
/*
 * key detection configuration, debounce timing and manual switch
 * override registers, with the key event and conversion control they steer.
 * assumes the serial control interface presents an 8-bit register port on
 * clk, that the device settings register supplies the override level, and
 * that insertion logic supplies removal pulses and automatic switch states.
 */
`timescale 1ns/1ps
module key_detect_regs
    import keydet_pkg::*;
#(
    parameter int unsigned CLK_KHZ = CLK_KHZ_DEF,
    parameter int unsigned DB_2MS_CYC = DB_2MS_MS * CLK_KHZ,
    parameter int unsigned DB_40MS_CYC = DB_40MS_MS * CLK_KHZ,
    parameter int unsigned DB_80MS_CYC = DB_80MS_MS * CLK_KHZ,
    parameter int unsigned DB_120MS_CYC = DB_120MS_MS * CLK_KHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port from the serial control interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    // device context
    input wire logic switch_override,
    input wire logic removal_event,
    input wire logic key_routing_ok,
    input wire switch_set_t auto_switch,
    // key comparator pin, asynchronous
    input wire logic key_level_pin,
    // adc
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [CONV_W-1:0] adc_result,
    // to the analog front end and interrupt logic
    output logic [BIAS_W-1:0] mic_bias_level,
    output switch_set_t switch_state,
    output logic key_detect_on,
    output key_events_t key_event,
    output logic [CONV_W-1:0] conv_output
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [DB_W-1:0] press_cycles(
        input logic [PRESS_W-1:0] code
    );
        logic [DB_W-1:0] c;
        c = DB_W'(DB_120MS_CYC);
        if (code == PRESS_CODE_2MS) begin
            c = DB_W'(DB_2MS_CYC);
        end else if (code == PRESS_CODE_40MS) begin
            c = DB_W'(DB_40MS_CYC);
        end else if (code == PRESS_CODE_80MS) begin
            c = DB_W'(DB_80MS_CYC);
        end
        return c;
    endfunction

    // both release codes select the same nominal time
    function automatic logic [DB_W-1:0] release_cycles(input logic code);
        logic [DB_W-1:0] c;
        c = DB_W'(DB_2MS_CYC);
        if (code == REL_RST) begin
            c = DB_W'(DB_2MS_CYC);
        end
        return c;
    endfunction

    function automatic logic hit(
        input logic [7:0] a,
        input logic [7:0] target
    );
        return a == target;
    endfunction

    // ************************************************************
    // state and submodule wiring
    // ************************************************************
    regs_state_t st_ff;
    regs_state_t nxt_st;

    logic db_rise;
    logic db_fall;
    logic conv_start;
    logic conv_busy;
    logic conv_done;
    logic [CONV_W-1:0] conv_result;
    logic [DB_W-1:0] press_lim;
    logic [DB_W-1:0] release_lim;

    // nominal counts only; the documented spread is the analog side's
    assign press_lim = press_cycles(st_ff.press_db);
    assign release_lim = release_cycles(st_ff.rel_db);

    key_debounce #(
        .W(DB_W)
    ) u_debounce (
        .clk(clk),
        .rstn(rstn),
        .enable(st_ff.active),
        .press_limit(press_lim),
        .release_limit(release_lim),
        .level_in(st_ff.key_sync[1]),
        .level_out(),
        .rise(db_rise),
        .fall(db_fall)
    );

    conv_sequencer u_conv (
        .clk(clk),
        .rstn(rstn),
        .start(conv_start),
        .busy(conv_busy),
        .done(conv_done),
        .result(conv_result),
        .adc_start(adc_start),
        .adc_done(adc_done),
        .adc_result(adc_result)
    );

    // a pending manual request outranks a press-started conversion
    // a press while busy gets no conversion of its own
    always_comb begin
        conv_start = 1'b0;
        if (!conv_busy) begin
            if (st_ff.trig && !st_ff.man_issued) begin
                conv_start = 1'b1;
            end else if (st_ff.raw && db_rise) begin
                conv_start = 1'b1;
            end
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic wr_cfg;
        logic wr_tim;
        logic wr_sw;
        wr_cfg = reg_wr_en && hit(reg_addr, KEY_DETECT_CONFIG_ADDR);
        wr_tim = reg_wr_en && hit(reg_addr, KEY_DETECT_TIMING_ADDR);
        wr_sw = reg_wr_en && hit(reg_addr, SWITCH_OVERRIDE_ADDR);

        nxt_st = st_ff;
        // pulses, low unless set below
        nxt_st.evt = '0;

        // only the second stage is read by logic
        nxt_st.key_sync = {st_ff.key_sync[0], key_level_pin};

        // ****************
        // register writes
        // ****************
        // configuration writes; reserved bits dropped
        if (wr_cfg) begin
            nxt_st.ken = reg_wr_data[KEN_BIT];
            nxt_st.raw = reg_wr_data[RAW_BIT];
        end

        // removal beats a same-cycle write of the enable
        if (removal_event) begin
            nxt_st.ken = 1'b0;
        end
        if (!nxt_st.ken) begin
            nxt_st.raw = 1'b0;
        end

        // ****************
        // conversion control
        // ****************
        // completion first: a same-cycle request survives
        if (conv_done) begin
            nxt_st.conv_out = conv_result;
            nxt_st.evt.conv_done_set = 1'b1;
            if (st_ff.man_issued) begin
                nxt_st.trig = 1'b0;
                nxt_st.man_issued = 1'b0;
            end
        end

        // request taken only with both modes on, whatever flags pend
        if (wr_cfg && reg_wr_data[TRIG_BIT]
            && nxt_st.ken && nxt_st.raw) begin
            nxt_st.trig = 1'b1;
        end

        // issued mark holds until the adc answers
        if (conv_start && st_ff.trig && !st_ff.man_issued) begin
            nxt_st.man_issued = 1'b1;
        end

        // a request not yet issued dies with its enables
        if (st_ff.trig && !st_ff.man_issued && !(nxt_st.ken && nxt_st.raw)
            && !conv_start) begin
            nxt_st.trig = 1'b0;
        end

        // codes act from the next edge
        if (wr_tim) begin
            nxt_st.bias = reg_wr_data[BIAS_LSB +: BIAS_W];
            nxt_st.rel_db = reg_wr_data[REL_BIT];
            nxt_st.press_db = reg_wr_data[PRESS_LSB +: PRESS_W];
        end

        // kept while override is off
        if (wr_sw) begin
            nxt_st.sw_reg = reg_wr_data[SW_W-1:0];
        end

        // ****************
        // key path and switches
        // ****************
        // detection gate
        nxt_st.active = nxt_st.ken
            && (!switch_override || key_routing_ok);

        // events; raw mode never clears existing key flags
        if (db_rise) begin
            if (st_ff.raw) begin
                nxt_st.evt.raw_press = 1'b1;
            end else begin
                nxt_st.evt.key_event_press = 1'b1;
            end
        end

        if (db_fall) begin
            if (st_ff.raw) begin
                nxt_st.evt.raw_release = 1'b1;
            end else begin
                nxt_st.evt.key_event_release = 1'b1;
            end
        end

        // override follows the written bits straight away
        if (switch_override) begin
            nxt_st.sw_out = nxt_st.sw_reg;
        end else begin
            nxt_st.sw_out = auto_switch;
        end

        // ****************
        // read back
        // ****************
        // read data, unmapped and reserved give zero
        // held so a slow serial side can shift it out
        nxt_st.rd_data = st_ff.rd_data;
        if (reg_rd_en) begin
            nxt_st.rd_data = RD_ZERO;
            if (hit(reg_addr, KEY_DETECT_CONFIG_ADDR)) begin
                nxt_st.rd_data[KEN_BIT] = st_ff.ken;
                nxt_st.rd_data[RAW_BIT] = st_ff.raw;
                nxt_st.rd_data[TRIG_BIT] = st_ff.trig;
            end else if (hit(reg_addr, KEY_DETECT_TIMING_ADDR)) begin
                nxt_st.rd_data[BIAS_LSB +: BIAS_W] = st_ff.bias;
                nxt_st.rd_data[REL_BIT] = st_ff.rel_db;
                nxt_st.rd_data[PRESS_LSB +: PRESS_W] = st_ff.press_db;
            end else if (hit(reg_addr, SWITCH_OVERRIDE_ADDR)) begin
                nxt_st.rd_data[SW_W-1:0] = st_ff.sw_reg;
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff.ken <= 1'b0;
            st_ff.raw <= 1'b0;
            st_ff.trig <= 1'b0;
            st_ff.man_issued <= 1'b0;
            st_ff.bias <= BIAS_RST;
            st_ff.rel_db <= REL_RST;
            st_ff.press_db <= PRESS_RST;
            st_ff.sw_reg <= SW_REG_RST;
            st_ff.sw_out <= SW_OUT_RST;
            st_ff.key_sync <= 2'h0;
            st_ff.rd_data <= RD_ZERO;
            st_ff.active <= 1'b0;
            st_ff.evt <= '0;
            st_ff.conv_out <= CONV_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign reg_rd_data = st_ff.rd_data;
    assign mic_bias_level = st_ff.bias;
    assign switch_state = st_ff.sw_out;
    assign key_detect_on = st_ff.active;
    assign key_event = st_ff.evt;
    assign conv_output = st_ff.conv_out;
endmodule

//--- shared/keydet_pkg.sv
/*
 * constants, field layouts and carrier types of the key detection and
 * switch override register bank.
 * assumes a 10 mhz core clock and an 8-bit internal register port that
 * the serial control interface drives.
 */
// Operation
// - key detect enable turns detection on; accessory removal clears it.
// - with override on, detection runs only when routing matrix position allowed.
// - raw sample enable clears itself whenever key detect enable goes zero.
// - entering raw sample mode leaves key event interrupt flags untouched.
// - raw mode reports every press and release and every conversion result.
// - conversion request starts only with key detect and raw sample enabled.
// - finished conversion sets done flag and loads the conversion output.
// - conversion request bit clears itself when its conversion finishes.
// - new request accepted even while previous done flag stays pending.
// - three-bit mic bias code, reset 1h, sets press threshold 2.1-2.8 v.
// - one-bit release debounce, reset 1h; both codes mean 2 ms.
// - two-bit press debounce, reset 2h: 2, 40, 80, 120 ms.
// - debounce times are typical; up to thirty percent plus 1 ms spread.
// - switch control bits matter only while switch override is on.
// - bit 5..0: sleeve gnd, ring2 gnd, sleeve dep, ring2 dep, sw2, sw1.
// - override bit set: switches follow switch control register at once.
package keydet_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] KEY_DETECT_CONFIG_ADDR = 8'h05;
    localparam logic [7:0] KEY_DETECT_TIMING_ADDR = 8'h06;
    localparam logic [7:0] SWITCH_OVERRIDE_ADDR = 8'h07;

    localparam int KEN_BIT = 2;
    localparam int RAW_BIT = 1;
    localparam int TRIG_BIT = 0;
    localparam int BIAS_LSB = 3;
    localparam int BIAS_W = 3;
    localparam int REL_BIT = 2;
    localparam int PRESS_LSB = 0;
    localparam int PRESS_W = 2;
    localparam int SW_W = 6;
    localparam int CONV_W = 7;

    localparam logic [2:0] BIAS_RST = 3'h1;
    localparam logic REL_RST = 1'h1;
    localparam logic [1:0] PRESS_RST = 2'h2;
    localparam logic [7:0] RD_ZERO = 8'h00;
    localparam logic [CONV_W-1:0] CONV_RST = 7'h00;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_KHZ_DEF = 10000;
    localparam int unsigned DB_2MS_MS = 2;
    localparam int unsigned DB_40MS_MS = 40;
    localparam int unsigned DB_80MS_MS = 80;
    localparam int unsigned DB_120MS_MS = 120;
    localparam int DB_W = 21;

    localparam logic [1:0] PRESS_CODE_2MS = 2'h0;
    localparam logic [1:0] PRESS_CODE_40MS = 2'h1;
    localparam logic [1:0] PRESS_CODE_80MS = 2'h2;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic sleeve_ground_fet;
        logic second_ring_ground_fet;
        logic sleeve_depletion_fet;
        logic second_ring_depletion_fet;
        logic switch_two;
        logic switch_one;
    } switch_set_t;

    // depletion fets on while nothing has been decided yet
    localparam switch_set_t SW_OUT_RST = 6'h0c;
    localparam switch_set_t SW_REG_RST = 6'h00;

    typedef struct packed {
        logic key_event_press;
        logic key_event_release;
        logic raw_press;
        logic raw_release;
        logic conv_done_set;
    } key_events_t;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_WAIT = 2'b01
    } conv_state_t;

    typedef struct packed {
        logic ken;
        logic raw;
        logic trig;
        logic man_issued;
        logic [BIAS_W-1:0] bias;
        logic rel_db;
        logic [PRESS_W-1:0] press_db;
        switch_set_t sw_reg;
        switch_set_t sw_out;
        logic [1:0] key_sync;
        logic [7:0] rd_data;
        logic active;
        key_events_t evt;
        logic [CONV_W-1:0] conv_out;
    } regs_state_t;

endpackage

//--- hw/key_debounce.sv
/*
 * debounce timer for the synchronised key comparator level.
 * assumes its input is already on clk; limits are cycle counts, at least 1.
 */
`timescale 1ns/1ps
module key_debounce
    import keydet_pkg::*;
#(
    parameter int W = DB_W
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic enable,
    input wire logic [W-1:0] press_limit,
    input wire logic [W-1:0] release_limit,
    // level in, events out
    input wire logic level_in,
    output logic level_out,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic level;
        logic [W-1:0] cnt;
        logic rise;
        logic fall;
    } db_state_t;

    db_state_t st_ff;
    db_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rise = 1'b0;
        nxt_st.fall = 1'b0;
        if (!enable) begin
            // disabling forgets a held key so no stale release appears
            nxt_st.level = 1'b0;
            nxt_st.cnt = '0;
        end else if (level_in == st_ff.level) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt + W'(1) >= (level_in ? press_limit
                                                     : release_limit)) begin
            nxt_st.level = level_in;
            nxt_st.cnt = '0;
            nxt_st.rise = level_in;
            nxt_st.fall = ~level_in;
        end else begin
            nxt_st.cnt = st_ff.cnt + W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level_out = st_ff.level;
    assign rise = st_ff.rise;
    assign fall = st_ff.fall;
endmodule

//--- hw/conv_sequencer.sv
/*
 * one-at-a-time conversion sequencer in front of the key adc.
 * assumes adc_done is a one-cycle pulse on clk with adc_result valid.
 */
`timescale 1ns/1ps
module conv_sequencer
    import keydet_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request side
    input wire logic start,
    output logic busy,
    output logic done,
    output logic [CONV_W-1:0] result,
    // adc side
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [CONV_W-1:0] adc_result
);
    typedef struct packed {
        conv_state_t state;
        logic adc_start;
        logic done;
        logic [CONV_W-1:0] result;
    } seq_state_t;

    seq_state_t st_ff;
    seq_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.adc_start = 1'b0;
        nxt_st.done = 1'b0;
        unique case (st_ff.state)
            CONV_IDLE: begin
                if (start) begin
                    nxt_st.adc_start = 1'b1;
                    nxt_st.state = CONV_WAIT;
                end
            end
            CONV_WAIT: begin
                if (adc_done) begin
                    nxt_st.done = 1'b1;
                    nxt_st.result = adc_result;
                    nxt_st.state = CONV_IDLE;
                end
            end
            default: nxt_st.state = CONV_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{CONV_IDLE, 1'b0, 1'b0, CONV_RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busy = (st_ff.state != CONV_IDLE);
    assign done = st_ff.done;
    assign result = st_ff.result;
    assign adc_start = st_ff.adc_start;
endmodule

//--- test/key_detect_regs_props.sv
/*
 * port checker for the key detection and switch override registers.
 * assumes one clock domain on clk and the async active-low rstn.
 */
`timescale 1ns/1ps
module key_detect_regs_props
    import keydet_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rd_data,
    // device context
    input wire logic switch_override,
    input wire logic removal_event,
    input wire logic key_routing_ok,
    input wire switch_set_t auto_switch,
    input wire logic key_level_pin,
    // adc and outputs
    input wire logic adc_start,
    input wire logic adc_done,
    input wire logic [CONV_W-1:0] adc_result,
    input wire logic [BIAS_W-1:0] mic_bias_level,
    input wire switch_set_t switch_state,
    input wire logic key_detect_on,
    input wire key_events_t key_event,
    input wire logic [CONV_W-1:0] conv_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_bias;
        reg_wr_en && reg_addr == 8'h06
            |=> mic_bias_level == $past(reg_wr_data[5:3]);
    endproperty
    a_bias:
        assert property (p_bias) else $error("bias code not applied");
    property p_sw_auto;
        !switch_override |=> switch_state == $past(auto_switch);
    endproperty
    a_sw_auto:
        assert property (p_sw_auto) else $error("auto switches not followed");
    property p_sw_man;
        switch_override && reg_wr_en && reg_addr == 8'h07
            |=> switch_state == $past(reg_wr_data[5:0]);
    endproperty
    a_sw_man:
        assert property (p_sw_man) else $error("manual switches not applied");
    property p_removal;
        removal_event |-> ##[1:2] !key_detect_on;
    endproperty
    a_removal:
        assert property (p_removal) else $error("detection kept on");
    property p_route;
        (switch_override && !key_routing_ok) [*2] |-> !key_detect_on;
    endproperty
    a_route:
        assert property (p_route) else $error("detection with bad routing");
    property p_conv;
        adc_done |-> ##2 key_event.conv_done_set
            && conv_output == $past(adc_result, 2);
    endproperty
    a_conv:
        assert property (p_conv) else $error("conversion not recorded");
    property p_trig_gate;
        reg_wr_en && reg_addr == 8'h05 && !reg_wr_data[1] |-> ##2 !adc_start;
    endproperty
    a_trig_gate:
        assert property (p_trig_gate) else $error("conversion without raw");
    property p_unmapped;
        reg_rd_en && (reg_addr < 8'h05 || reg_addr > 8'h07)
            |=> reg_rd_data == 8'h00;
    endproperty
    a_unmapped:
        assert property (p_unmapped) else $error("unmapped read not zero");
    property p_rsv;
        reg_rd_en |=> reg_rd_data[7:6] == 2'h0
            && ($past(reg_addr) != 8'h05 || reg_rd_data[5:3] == 3'h0);
    endproperty
    a_rsv:
        assert property (p_rsv) else $error("reserved bits not zero");

    c_conv: cover property (adc_done);
    c_raw: cover property (key_event.raw_press);
    c_norm: cover property (key_event.key_event_press);
endmodule

bind key_detect_regs key_detect_regs_props u_props (.*);

//--- test/adc_model.sv
/*
 * adc stand-in that answers adc_start after a latency set by the bench.
 * assumes adc_start is a one-cycle pulse on clk.
 */
`timescale 1ns/1ps
module adc_model
    import keydet_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // from the bench
    input wire logic [3:0] adc_lat,
    input wire logic [CONV_W-1:0] adc_val,
    // adc port
    input wire logic adc_start,
    output logic adc_done,
    output logic [CONV_W-1:0] adc_result
);
    logic busy_ff;
    logic [3:0] cnt_ff;

    // result toggles outside done so a stale sample never matches
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_ff <= 1'b0;
            cnt_ff <= 4'h0;
            adc_done <= 1'b0;
            adc_result <= 7'h2a;
        end else begin
            adc_done <= 1'b0;
            adc_result <= ~adc_result;
            if (adc_start) begin
                busy_ff <= 1'b1;
                cnt_ff <= adc_lat;
            end else if (busy_ff && cnt_ff == 4'h0) begin
                busy_ff <= 1'b0;
                adc_done <= 1'b1;
                adc_result <= adc_val;
            end else if (busy_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule

//--- test/key_detect_regs_bench.sv
/*
 * self-checking bench for key_detect_regs with an adc model.
 * assumes debounce counts shrunk to 4/8/12/16 cycles, 10 mhz clock.
 */
`timescale 1ns/1ps
module key_detect_regs_bench
    import keydet_pkg::*;
;
    logic clk, rstn, reg_wr_en, reg_rd_en, switch_override, removal_event;
    logic key_routing_ok, key_level_pin, adc_start, adc_done, key_detect_on;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic [CONV_W-1:0] adc_result, conv_output, adc_val;
    logic [BIAS_W-1:0] mic_bias_level;
    logic [3:0] adc_lat;
    switch_set_t auto_switch, switch_state;
    key_events_t key_event;
    int n_mismatch = 0, checked = 0, n_start = 0, n_done = 0;
    int n_rp = 0, n_rr = 0, n_kp = 0, n_kr = 0, n_cd = 0;
    localparam int DB [4] = '{4, 8, 12, 16};

    key_detect_regs #(.DB_2MS_CYC(4), .DB_40MS_CYC(8), .DB_80MS_CYC(12),
        .DB_120MS_CYC(16)) u_dut (.*);
    adc_model u_adc (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // pulses counted here so no test misses a one-cycle event
    always @(posedge clk) begin
        if (adc_start) n_start++;
        if (adc_done) n_done++;
        if (key_event.conv_done_set) n_cd++;
        if (key_event.raw_press) n_rp++;
        if (key_event.raw_release) n_rr++;
        if (key_event.key_event_press) n_kp++;
        if (key_event.key_event_release) n_kr++;
    end

    // ********
    // helpers
    // ********
    task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk) #1;
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(posedge clk) #1;
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk) #1;
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge clk) #1;
        reg_rd_en = 1'b0;
        @(posedge clk) #1;
        chk(reg_rd_data, e, "read");
    endtask
    // bounded wait for a counter to move; t is the cycles taken
    task automatic wait_inc(ref int c, output int t);
        int c0;
        c0 = c;
        for (t = 0; t < 80 && c == c0; t++) @(posedge clk) #1;
    endtask
    task automatic done_test(string s);
        $display("test %s finished", s);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #1000000;
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end

    // ********
    // tests
    // ********
    initial begin
        int d, i, t, s0;
        {reg_addr, reg_wr_data, reg_wr_en, reg_rd_en} = '0;
        {switch_override, removal_event, key_routing_ok} = 3'h0;
        {auto_switch, key_level_pin, rstn} = '0;
        adc_lat = 4'h2;
        adc_val = 7'h11;
        void'($urandom(27352));
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        rd(8'h05, 8'h00);
        rd(8'h06, 8'h0e);
        rd(8'h07, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h08 + 8'($urandom_range(0, 200)), 8'h00);
        done_test("reset");
        for (i = 0; i < 8; i++) begin
            d = $urandom;
            wr(8'h06, 8'(d));
            rd(8'h06, 8'(d) & 8'h3f);
            chk({5'h0, mic_bias_level}, 8'(d) >> 3 & 8'h07, "bias");
            wr(8'h07, 8'(d >> 8));
            rd(8'h07, 8'(d >> 8) & 8'h3f);
        end
        done_test("registers");
        for (i = 0; i < 6; i++) begin
            auto_switch = switch_set_t'($urandom);
            switch_override = 1'b1;
            wr(8'h07, 8'h01 << i);
            @(posedge clk) #1;
            chk({2'h0, switch_state}, 8'h01 << i, "manual");
            switch_override = 1'b0;
            @(posedge clk) #1;
            chk({2'h0, switch_state}, {2'h0, auto_switch}, "auto");
        end
        done_test("switches");
        // done flag never serviced between requests
        for (i = 0; i < 3; i++) begin
            adc_lat = 4'($urandom);
            adc_val = 7'($urandom);
            wr(8'h05, 8'h07);
            wait_inc(n_done, t);
            @(posedge clk) #1;
            chk({1'h0, conv_output}, {1'h0, adc_val}, "conv");
            rd(8'h05, 8'h06);
            chk(8'(n_cd), 8'(i + 1), "done flag");
        end
        s0 = n_start;
        wr(8'h05, 8'h05);
        rd(8'h05, 8'h04);
        wr(8'h05, 8'h03);
        rd(8'h05, 8'h00);
        repeat (20) @(posedge clk);
        #1 chk(8'(n_start - s0), 8'h00, "start");
        wr(8'h05, 8'h06);
        removal_event = 1'b1;
        @(posedge clk) #1;
        removal_event = 1'b0;
        rd(8'h05, 8'h00);
        done_test("conversion");
        switch_override = 1'b1;
        wr(8'h05, 8'h04);
        repeat (2) @(posedge clk);
        #1 chk({7'h0, key_detect_on}, 8'h00, "gate off");
        key_routing_ok = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({7'h0, key_detect_on}, 8'h01, "gate on");
        switch_override = 1'b0;
        for (i = 0; i < 4; i++) begin
            wr(8'h06, 8'h08 | 8'(i) | 8'((i & 1) << 2));
            key_level_pin = 1'b1;
            wait_inc(n_kp, t);
            chk(8'(t >= DB[i] && t <= DB[i] + 6), 8'h01, "press");
            key_level_pin = 1'b0;
            wait_inc(n_kr, t);
            chk(8'(t >= DB[0] && t <= DB[0] + 6), 8'h01, "rel");
        end
        done_test("debounce");
        wr(8'h05, 8'h06);
        s0 = n_kp;
        d = n_start;
        key_level_pin = 1'b1;
        wait_inc(n_rp, t);
        chk(8'(t < 80), 8'h01, "raw press");
        wait_inc(n_done, t);
        chk(8'(n_start - d), 8'h01, "raw conv");
        key_level_pin = 1'b0;
        wait_inc(n_rr, t);
        chk(8'(t < 80), 8'h01, "raw release");
        chk(8'(n_kp - s0), 8'h00, "normal event");
        done_test("raw");
        end_sim();
    end
endmodule
